// ==== logic/pasc_top.sv ====
// pixel array pointer scan, row routing and output amplifier control with AHB-Lite registers
`timescale 1ns/100ps
`include "pasc_map.svh"

// Notes on behaviour
// - right row sync low returns pointer to start
// - right row pointer steps on clock fall
// - right end low on pulse after last
// - column sync low returns pointer to start
// - column pointer steps on clock fall
// - column end low on pulse after last
// - left row sync low returns pointer to start
// - left row pointer steps on clock fall
// - left end low on pulse after last
// - track-hold high holds, low tracks samples
// - column calibration active while input high
// - row pick selects addressed row
// - row reset resets addressed row
// - side choice picks left or right pointer
// - skip mode scans one in four, 320x256
// - amplifier input mux, array or auxiliary
// - input choice one is auxiliary, zero array
// - four-bit gain code, exponential gain steps
// - four-bit offset code, linear, gain independent
// - fast and slow offset calibration modes
// - fast calibration needs strobe and unity high
// - slow calibration converges over about 450 pulses from full scale
module pasc_top
    import pasc_pkg::*;
(
    input wire logic hclk, // system clock, 125 MHz
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic right_row_ptr_sync_n, // right row pointer sync, low active
    input wire logic right_row_ptr_clk, // right row pointer clock
    input wire logic left_row_ptr_sync_n, // left row pointer sync, low active
    input wire logic left_row_ptr_clk, // left row pointer clock
    input wire logic column_ptr_sync_n, // column pointer sync, low active
    input wire logic column_ptr_clk, // column pointer clock
    input wire logic row_track_hold, // 1 hold, 0 track
    input wire logic column_amp_calib, // 1 calibrate column amplifiers
    input wire logic row_pick, // 1 select addressed row
    input wire logic row_reset, // 1 reset addressed row
    input wire logic row_side_left, // 1 left pointer, 0 right
    input wire logic viewfinder_skip_mode, // 1 one-in-four scan
    input wire logic ext_input_sel, // 1 auxiliary input, 0 array
    input wire logic unity_gain_mode, // amplifier follower mode
    input wire logic calib_fast, // fast offset strobe
    input wire logic calib_slow, // slow offset strobe
    input wire logic [3:0] amp_gain_code, // gain code
    input wire logic [3:0] offset_level_code, // offset code
    output logic right_row_end_n, // right end of scan, low active
    output logic left_row_end_n, // left end of scan, low active
    output logic column_end_n, // column end of scan, low active
    output logic [10:0] row_addr, // row addressed by chosen pointer
    output logic row_select_on, // addressed row selected
    output logic row_reset_on, // addressed row in reset
    output logic [10:0] column_addr, // column being read
    output logic column_hold, // column samples held
    output logic column_calib_on, // column amplifiers calibrating
    output logic amp_input_ext, // amplifier fed from auxiliary input
    output logic [10:0] amp_gain_x100, // amplifier gain times 100
    output logic [9:0] offset_trim // applied offset level, 4.6 fixed point
);
    // ---- functions ----
    // last position of a pointer for the current scan mode
    function automatic logic [10:0] pasc_last(input pasc_ptr_idx_t idx, input logic skip);
        if (idx == 2'h2) begin
            pasc_last = skip ? `PASC_COL_LAST_SKIP : `PASC_COL_LAST;
        end else begin
            pasc_last = skip ? `PASC_ROW_LAST_SKIP : `PASC_ROW_LAST;
        end
    endfunction : pasc_last

    // exponential gain table
    function automatic logic [10:0] pasc_gain(input logic [3:0] code);
        case (code)
            4'h0: pasc_gain = 11'h080;
            4'h1: pasc_gain = 11'h097;
            4'h2: pasc_gain = 11'h0B6;
            4'h3: pasc_gain = 11'h0D5;
            4'h4: pasc_gain = 11'h104;
            4'h5: pasc_gain = 11'h137;
            4'h6: pasc_gain = 11'h173;
            4'h7: pasc_gain = 11'h1B8;
            4'h8: pasc_gain = 11'h215;
            4'h9: pasc_gain = 11'h27D;
            4'hA: pasc_gain = 11'h2E5;
            4'hB: pasc_gain = 11'h37B;
            4'hC: pasc_gain = 11'h42E;
            4'hD: pasc_gain = 11'h4F1;
            4'hE: pasc_gain = 11'h5DD;
            default: pasc_gain = 11'h6D9;
        endcase
    endfunction : pasc_gain

    // one slow calibration pulse: move a fraction of the gap, at least one step
    function automatic logic [9:0] pasc_slow_step(input logic [9:0] trim, input logic [9:0] tgt);
        logic signed [10:0] diff;
        logic signed [10:0] step;
        diff = $signed({1'b0, tgt}) - $signed({1'b0, trim});
        step = diff >>> `PASC_SLOW_SHIFT;
        if (diff != 11'sh000 && step == 11'sh000) begin
            step = (diff > 11'sh000) ? 11'sh001 : -11'sh001;
        end
        pasc_slow_step = 10'(trim + 10'(step));
    endfunction : pasc_slow_step

    // ---- pin synchronisers ----
    logic [`PASC_PIN_W-1:0] pin_raw;
    logic [`PASC_PIN_W-1:0] pin_meta;
    logic [`PASC_PIN_W-1:0] pin_s;
    logic [`PASC_PIN_W-1:0] pin_prev;

    assign pin_raw = {offset_level_code, amp_gain_code, calib_slow, calib_fast,
                      unity_gain_mode, ext_input_sel, viewfinder_skip_mode, row_side_left,
                      row_reset, row_pick, column_amp_calib, row_track_hold,
                      column_ptr_clk, column_ptr_sync_n, left_row_ptr_clk,
                      left_row_ptr_sync_n, right_row_ptr_clk, right_row_ptr_sync_n};

    // two flops before use; prev copy only for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 24'h00_0015;
            pin_s <= 24'h00_0015;
            pin_prev <= 24'h00_0015;
        end else begin
            pin_meta <= pin_raw;
            pin_s <= pin_meta;
            pin_prev <= pin_s;
        end
    end

    // ---- registers of the bus ----
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_phase;
    logic skip;

    assign addr_phase = hsel && htrans[1] && hready;
    assign skip = pin_s[`PASC_PIN_SKIP] || ctrl[`PASC_CTRL_FORCE_SKIP];

    // ---- pointer shift registers ----
    logic [10:0] pos [3];
    pasc_ptr_state_t pst [3];
    logic [2:0] ptr_sync_n;
    logic [2:0] ptr_clk;
    logic [2:0] ptr_fall;
    logic [2:0] end_n;

    // pointer i uses pin bits 2i (sync) and 2i+1 (clock)
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ptr_sync_n[i] = pin_s[2*i];
            ptr_clk[i] = pin_s[2*i+1];
            ptr_fall[i] = pin_prev[2*i+1] && !pin_s[2*i+1];
        end
    end

    // sync wins over clock; disabled core parks all pointers at start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 3; i++) begin
                pos[i] <= 11'h000;
                pst[i] <= PASC_SCAN;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!ptr_sync_n[i] || !ctrl[`PASC_CTRL_ENABLE]) begin
                    pos[i] <= 11'h000;
                    pst[i] <= PASC_SCAN;
                end else if (ptr_fall[i]) begin
                    case (pst[i])
                        PASC_SCAN: begin
                            if (pos[i] >= pasc_last(2'(i), skip)) begin
                                pst[i] <= PASC_PAST;
                            end else begin
                                pos[i] <= 11'(pos[i] + (skip ? `PASC_STEP_SKIP : `PASC_STEP_FULL));
                            end
                        end
                        PASC_PAST: pst[i] <= PASC_DONE;
                        PASC_DONE: pst[i] <= PASC_DONE;
                        default: pst[i] <= PASC_SCAN;
                    endcase
                end
            end
        end
    end

    // end flag only during the one clock pulse after the last position
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            end_n <= 3'h7;
        end else begin
            for (int i = 0; i < 3; i++) begin
                end_n[i] <= !(pst[i] == PASC_PAST && ptr_clk[i]);
            end
        end
    end
    assign right_row_end_n = end_n[0];
    assign left_row_end_n = end_n[1];
    assign column_end_n = end_n[2];

    // ---- row routing and column controls ----
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            row_addr <= 11'h000;
            row_select_on <= 1'b0;
            row_reset_on <= 1'b0;
            column_addr <= 11'h000;
            column_hold <= 1'b0;
            column_calib_on <= 1'b0;
        end else begin
            row_addr <= pin_s[`PASC_PIN_SIDE_LEFT] ? pos[1] : pos[0];
            row_select_on <= pin_s[`PASC_PIN_ROW_PICK];
            row_reset_on <= pin_s[`PASC_PIN_ROW_RESET];
            column_addr <= pos[2];
            column_hold <= pin_s[`PASC_PIN_TRACK_HOLD];
            column_calib_on <= pin_s[`PASC_PIN_COL_CALIB];
        end
    end

    // ---- output amplifier: mux, gain, offset calibration ----
    logic [3:0] gain_s;
    logic [9:0] trim_tgt;
    logic fast_fall;
    logic slow_fall;

    assign gain_s = pin_s[`PASC_PIN_GAIN_LO +: 4];
    assign trim_tgt = {pin_s[`PASC_PIN_OFS_LO +: 4], 6'h00};
    // fast adjust lands when the strobe falls while follower mode is on
    assign fast_fall = pin_prev[`PASC_PIN_CAL_FAST] && !pin_s[`PASC_PIN_CAL_FAST]
                       && pin_s[`PASC_PIN_UNITY];
    // slow adjust takes one step toward the offset code target on the strobe's falling edge
    assign slow_fall = pin_prev[`PASC_PIN_CAL_SLOW] && !pin_s[`PASC_PIN_CAL_SLOW];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amp_input_ext <= 1'b0;
            amp_gain_x100 <= 11'h080;
        end else begin
            amp_input_ext <= pin_s[`PASC_PIN_EXT_SEL];
            amp_gain_x100 <= pasc_gain(gain_s);
        end
    end

    // fast wins if both strobes fall together: it lands the full target anyway
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offset_trim <= 10'h000;
        end else if (fast_fall) begin
            offset_trim <= trim_tgt;
        end else if (slow_fall) begin
            offset_trim <= pasc_slow_step(offset_trim, trim_tgt);
        end
    end

    // ---- AHB-Lite slave, zero wait states ----
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr;
        end
    end

    // write data lands in the data phase; only control is writable
    always_comb begin
        next_ctrl = ctrl;
        if (wr_pend && wr_addr == `PASC_OFS_CTRL) begin
            next_ctrl = hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `PASC_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // read data is latched at the address phase; next_ctrl forwards a write just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr)
                `PASC_OFS_CTRL: hrdata <= {30'h0000_0000, next_ctrl};
                // top three bits are spare and read as zero
                `PASC_OFS_STATUS: hrdata <= {3'h0, pst[2], pst[1], pst[0], end_n, pin_s[15:6],
                                             10'h000};
                `PASC_OFS_RIGHT_POS: hrdata <= {21'h00_0000, pos[0]};
                `PASC_OFS_LEFT_POS: hrdata <= {21'h00_0000, pos[1]};
                `PASC_OFS_COL_POS: hrdata <= {21'h00_0000, pos[2]};
                `PASC_OFS_AMP: hrdata <= {2'h0, offset_trim, amp_gain_x100,
                                          pin_s[`PASC_PIN_OFS_LO +: 4], gain_s, 1'b0};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---- assertions ----
    default clocking pasc_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_RIGHT_SYNC: assert property (!ptr_sync_n[0] |=>
        pos[0] == 11'h000 && pst[0] == PASC_SCAN)
        else $error("right pointer not at start after sync");
    AST_COL_SYNC: assert property (!ptr_sync_n[2] |=>
        pos[2] == 11'h000 && pst[2] == PASC_SCAN)
        else $error("column pointer not at start after sync");
    AST_LEFT_SYNC: assert property (!ptr_sync_n[1] |=> pos[1] == 11'h000)
        else $error("left pointer not at start after sync");
    AST_RIGHT_STEP: assert property (ptr_fall[0] && ptr_sync_n[0] && ctrl[0] && !skip
        && pst[0] == PASC_SCAN && pos[0] < `PASC_ROW_LAST |=> pos[0] == $past(pos[0]) + 11'h001)
        else $error("right pointer did not step by one");
    AST_COL_HOLD: assert property (!ptr_fall[2] && ptr_sync_n[2] && ctrl[0] |=>
        $stable(pos[2]))
        else $error("column pointer moved without a clock fall");
    AST_LEFT_STEP: assert property (ptr_fall[1] && ptr_sync_n[1] && ctrl[0] && skip
        && pst[1] == PASC_SCAN && pos[1] < `PASC_ROW_LAST_SKIP
        |=> pos[1] == $past(pos[1]) + 11'h004)
        else $error("left pointer did not step by four in skip mode");
    AST_RIGHT_END: assert property (pst[0] == PASC_PAST && ptr_clk[0] |=>
        !right_row_end_n)
        else $error("right end flag missing");
    AST_COL_END_ONLY: assert property (pst[2] != PASC_PAST |=> column_end_n)
        else $error("column end flag outside its pulse");
    AST_LEFT_END: assert property (pst[1] == PASC_PAST && ptr_clk[1] |=> !left_row_end_n)
        else $error("left end flag missing");
    AST_SIDE: assert property (##1 row_addr == (pin_prev[`PASC_PIN_SIDE_LEFT] ?
        $past(pos[1]) : $past(pos[0])))
        else $error("row address taken from the wrong pointer");
    AST_SKIP_LAST: assert property (skip && pst[2] == PASC_SCAN |->
        pos[2] <= `PASC_COL_LAST)
        else $error("column pointer past array end");
    AST_MUX: assert property (##1 amp_input_ext == $past(pin_s[`PASC_PIN_EXT_SEL]))
        else $error("amplifier input choice not followed");
    AST_GAIN: assert property (##2 amp_gain_x100 == pasc_gain($past(gain_s, 1)))
        else $error("gain does not match code");
    AST_FAST: assert property (fast_fall |=> offset_trim == $past(trim_tgt))
        else $error("fast calibration did not land in one cycle");
    AST_SLOW: assert property (slow_fall && !fast_fall && offset_trim != trim_tgt
        |=> offset_trim != $past(offset_trim))
        else $error("slow calibration pulse did not move the offset");
    AST_NO_CAL: assert property (!slow_fall && !fast_fall |=> $stable(offset_trim))
        else $error("offset moved without a strobe");

    COV_ROW_END: cover property (pst[0] == PASC_PAST ##1 !right_row_end_n);
    COV_COL_SKIP_END: cover property (skip && pst[2] == PASC_PAST);
    COV_FAST_CAL: cover property (fast_fall);
    COV_SLOW_CAL: cover property (slow_fall ##1 offset_trim != 10'h000);
    COV_LEFT_END: cover property (pst[1] == PASC_PAST ##1 !left_row_end_n);
endmodule : pasc_top

// ==== logic/pasc_map.svh ====
// address map, field positions, reset values and scan limits of the pixel scan control
`ifndef PASC_MAP_SVH
`define PASC_MAP_SVH

// register byte offsets
`define PASC_OFS_CTRL 8'h00
`define PASC_OFS_STATUS 8'h04
`define PASC_OFS_RIGHT_POS 8'h08
`define PASC_OFS_LEFT_POS 8'h0C
`define PASC_OFS_COL_POS 8'h10
`define PASC_OFS_AMP 8'h14

// control register fields and reset value
`define PASC_CTRL_ENABLE 0
`define PASC_CTRL_FORCE_SKIP 1
`define PASC_CTRL_RESET 2'h1

// bit positions in the synchronised pin vector
`define PASC_PIN_W 24
`define PASC_PIN_TRACK_HOLD 6
`define PASC_PIN_COL_CALIB 7
`define PASC_PIN_ROW_PICK 8
`define PASC_PIN_ROW_RESET 9
`define PASC_PIN_SIDE_LEFT 10
`define PASC_PIN_SKIP 11
`define PASC_PIN_EXT_SEL 12
`define PASC_PIN_UNITY 13
`define PASC_PIN_CAL_FAST 14
`define PASC_PIN_CAL_SLOW 15
`define PASC_PIN_GAIN_LO 16
`define PASC_PIN_OFS_LO 20

// pointer limits: full scan and one-in-four viewfinder scan
`define PASC_ROW_LAST 11'h405
`define PASC_COL_LAST 11'h505
`define PASC_ROW_LAST_SKIP 11'h3FC
`define PASC_COL_LAST_SKIP 11'h4FC
`define PASC_STEP_FULL 11'h001
`define PASC_STEP_SKIP 11'h004

// offset trim: code placed above this many fraction bits, slow step divisor shift
`define PASC_TRIM_FRAC 6
`define PASC_SLOW_SHIFT 7

`endif

// ==== logic/pasc_pkg.sv ====
// types shared by the pixel scan control
package pasc_pkg;
    // phase of one pointer shift register
    typedef enum logic [1:0] {PASC_SCAN, PASC_PAST, PASC_DONE} pasc_ptr_state_t;
    // pointer index: 0 right row, 1 left row, 2 column
    typedef logic [1:0] pasc_ptr_idx_t;
endpackage : pasc_pkg

// ==== test/pasc_tc.sv ====
// timing controller model: pointer clocks, syncs and control levels
`timescale 1ns/100ps
module pasc_tc (
    input wire logic hclk, // pacing clock
    output logic right_row_ptr_sync_n, // right sync
    output logic right_row_ptr_clk, // right clock
    output logic left_row_ptr_sync_n, // left sync
    output logic left_row_ptr_clk, // left clock
    output logic column_ptr_sync_n, // column sync
    output logic column_ptr_clk, // column clock
    output logic row_track_hold, // hold level
    output logic column_amp_calib, // calibrate level
    output logic row_pick, // select level
    output logic row_reset, // reset level
    output logic row_side_left, // side choice
    output logic viewfinder_skip_mode, // skip level
    output logic ext_input_sel, // input choice
    output logic unity_gain_mode, // follower mode
    output logic calib_fast, // fast strobe
    output logic calib_slow, // slow strobe
    output logic [3:0] amp_gain_code, // gain code
    output logic [3:0] offset_level_code // offset code
);
    logic [2:0] ptr_clk; // 0 right, 1 left, 2 column
    logic [2:0] ptr_sync_n;
    assign {column_ptr_clk, left_row_ptr_clk, right_row_ptr_clk} = ptr_clk;
    assign {column_ptr_sync_n, left_row_ptr_sync_n, right_row_ptr_sync_n} = ptr_sync_n;
    // idle levels; gain kept at the floor advised for the on-chip converter
    initial begin
        ptr_clk = 3'h0;
        ptr_sync_n = 3'h7;
        {row_track_hold, column_amp_calib, row_pick, row_reset, row_side_left,
            viewfinder_skip_mode, ext_input_sel, unity_gain_mode, calib_fast, calib_slow} = '0;
        amp_gain_code = 4'h3;
        offset_level_code = 4'h0;
    end
    // each level held 7 periods, twice the minimum the pins need
    task automatic clk_to(input int w, input logic lvl);
        @(posedge hclk);
        ptr_clk[w] <= lvl;
        repeat (6) @(posedge hclk);
    endtask : clk_to
    // clock stands low between pulses; no clocks while codes change
    task automatic pulses(input int w, input int n);
        for (int i = 0; i < n; i++) begin
            clk_to(w, 1'b1);
            clk_to(w, 1'b0);
        end
    endtask : pulses
    // sync low with the clock parked low
    task automatic sync(input int w);
        @(posedge hclk);
        ptr_sync_n[w] <= 1'b0;
        repeat (6) @(posedge hclk);
        ptr_sync_n[w] <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask : sync
    // calibration strobe, its falling edge is what counts
    task automatic strobe(input logic slow);
        @(posedge hclk);
        if (slow) calib_slow <= 1'b1;
        else calib_fast <= 1'b1;
        repeat (6) @(posedge hclk);
        calib_slow <= 1'b0;
        calib_fast <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : strobe
endmodule : pasc_tc

// ==== test/pixel_array_scan_control_test.sv ====
// self-checking bench for the pixel scan control
`timescale 1ns/100ps
`include "pasc_map.svh"
module pixel_array_scan_control_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready, hreadyout, hresp, row_select_on, row_reset_on, column_hold;
    wire logic [31:0] hrdata;
    wire logic right_row_ptr_sync_n, right_row_ptr_clk, left_row_ptr_sync_n, left_row_ptr_clk;
    wire logic column_ptr_sync_n, column_ptr_clk, row_track_hold, column_amp_calib, row_pick;
    wire logic row_reset, row_side_left, viewfinder_skip_mode, ext_input_sel, unity_gain_mode;
    wire logic calib_fast, calib_slow, right_row_end_n, left_row_end_n, column_end_n;
    wire logic column_calib_on, amp_input_ext;
    wire logic [3:0] amp_gain_code, offset_level_code;
    wire logic [10:0] row_addr, column_addr, amp_gain_x100;
    wire logic [9:0] offset_trim;
    wire logic [2:0] end_flags = {column_end_n, left_row_end_n, right_row_end_n};
    int fail_count = 0;
    int checks_done = 0;
    assign hready = hreadyout;
    pasc_top i_pasc_top (.*);
    pasc_tc i_pasc_tc (.*);
    always #4 hclk = ~hclk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic settle;
        repeat (6) @(posedge hclk);
    endtask : settle
    task automatic test_regs;
        logic [31:0] rd;
        ahb(1'b0, `PASC_OFS_CTRL, 32'h0000_0000, rd);
        check("ctrl reset", 32'h0000_0001, rd);
        ahb(1'b1, `PASC_OFS_CTRL, 32'h0000_0003, rd);
        ahb(1'b0, `PASC_OFS_CTRL, 32'h0000_0000, rd);
        check("ctrl rw", 32'h0000_0003, rd);
        ahb(1'b1, `PASC_OFS_CTRL, 32'h0000_0001, rd);
        ahb(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h40, 32'h0000_0000, rd);
        check("unmapped", 32'h0000_0000, rd);
        check("hresp", 32'h0000_0000, {31'h0, hresp});
        $display("test_regs done");
    endtask : test_regs
    // levels pass through to the array side, both polarities
    task automatic test_levels;
        for (int v = 1; v >= 0; v--) begin
            @(posedge hclk);
            i_pasc_tc.row_pick <= v[0];
            i_pasc_tc.row_reset <= v[0];
            i_pasc_tc.row_track_hold <= v[0];
            i_pasc_tc.column_amp_calib <= v[0];
            i_pasc_tc.ext_input_sel <= v[0];
            settle();
            check("levels", {27'h0, {5{v[0]}}}, {27'h0, row_select_on, row_reset_on,
                column_hold, column_calib_on, amp_input_ext});
        end
        $display("test_levels done");
    endtask : test_levels
    task automatic test_gain;
        logic [10:0] tab [16] = '{11'h080, 11'h097, 11'h0B6, 11'h0D5, 11'h104, 11'h137,
            11'h173, 11'h1B8, 11'h215, 11'h27D, 11'h2E5, 11'h37B, 11'h42E, 11'h4F1,
            11'h5DD, 11'h6D9};
        for (int c = 0; c < 17; c++) begin
            @(posedge hclk);
            i_pasc_tc.amp_gain_code <= (c == 16) ? 4'h3 : c[3:0];
            settle();
            if (c < 16) check("gain", {21'h0, tab[c]}, {21'h0, amp_gain_x100});
        end
        $display("test_gain done");
    endtask : test_gain
    task automatic test_offset;
        logic [31:0] rd;
        @(posedge hclk);
        i_pasc_tc.offset_level_code <= 4'h8;
        i_pasc_tc.unity_gain_mode <= 1'b1;
        i_pasc_tc.strobe(1'b0);
        check("fast trim", 32'h0000_0200, {22'h0, offset_trim});
        i_pasc_tc.offset_level_code <= 4'h2;
        i_pasc_tc.unity_gain_mode <= 1'b0;
        i_pasc_tc.strobe(1'b0);
        check("fast no unity", 32'h0000_0200, {22'h0, offset_trim});
        i_pasc_tc.offset_level_code <= 4'h0;
        i_pasc_tc.strobe(1'b1);
        check("slow trim", 32'h0000_01FC, {22'h0, offset_trim});
        ahb(1'b0, `PASC_OFS_AMP, 32'h0000_0000, rd);
        check("amp reg", 32'h1FC1_AA06, rd);
        $display("test_offset done");
    endtask : test_offset
    // sync mid-scan, step, last position, end flag over the pulse after last
    task automatic scan_ptr(input int w, input int n, input int step, input logic [10:0] last);
        logic [31:0] rd;
        logic [7:0] ofs;
        ofs = `PASC_OFS_RIGHT_POS + 8'(4 * w);
        i_pasc_tc.row_side_left <= (w == 1);
        i_pasc_tc.sync(w);
        i_pasc_tc.pulses(w, 3);
        ahb(1'b0, ofs, 32'h0000_0000, rd);
        check("step", 32'(3 * step), rd);
        i_pasc_tc.sync(w);
        ahb(1'b0, ofs, 32'h0000_0000, rd);
        check("sync", 32'h0000_0000, rd);
        i_pasc_tc.pulses(w, n);
        ahb(1'b0, ofs, 32'h0000_0000, rd);
        check("last", {21'h0, last}, rd);
        check("addr", {21'h0, last}, {21'h0, (w == 2) ? column_addr : row_addr});
        // each end check is made while the clock pulse stands high
        i_pasc_tc.clk_to(w, 1'b1);
        check("end past", 32'h1, {31'h0, end_flags[w]});
        i_pasc_tc.clk_to(w, 1'b0);
        i_pasc_tc.clk_to(w, 1'b1);
        check("end low", 32'h0, {31'h0, end_flags[w]});
        i_pasc_tc.clk_to(w, 1'b0);
        i_pasc_tc.clk_to(w, 1'b1);
        check("end done", 32'h1, {31'h0, end_flags[w]});
        i_pasc_tc.clk_to(w, 1'b0);
        ahb(1'b0, ofs, 32'h0000_0000, rd);
        check("parked", {21'h0, last}, rd);
        $display("scan %0d done", w);
    endtask : scan_ptr
    task automatic wrap_up;
        $display("checks_done %0d fail_count %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        test_levels();
        test_gain();
        test_offset();
        scan_ptr(0, 1029, 1, `PASC_ROW_LAST);
        i_pasc_tc.viewfinder_skip_mode <= 1'b1;
        scan_ptr(1, 255, 4, `PASC_ROW_LAST_SKIP);
        i_pasc_tc.viewfinder_skip_mode <= 1'b0;
        i_pasc_tc.row_side_left <= 1'b0;
        settle();
        check("side right", {21'h0, `PASC_ROW_LAST}, {21'h0, row_addr});
        scan_ptr(2, 1285, 1, `PASC_COL_LAST);
        wrap_up();
    end
    // watchdog well beyond the some 36500 cycles of the sequence
    initial begin
        repeat (90000) @(posedge hclk);
        fail_count++;
        wrap_up();
    end
endmodule : pixel_array_scan_control_test
